//--- bench/buck_cfg_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "buck_cfg_regs.vh"

module buck_cfg_checker (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        cfg_load,
    input wire logic [2:0]  cfg_on_timeslot,
    input wire logic [1:0]  cfg_on_mode,
    input wire logic [4:0]  cfg_on_vcode_hi,
    input wire logic        seq_slot_strobe,
    input wire logic        seq_sleep,
    input wire logic        conv_enable,
    input wire logic        conv_in_sleep,
    input wire logic [6:0]  conv_vcode,
    input wire logic [14:0] conv_vout
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_undef_bits_zero: assert property (reg_rdata[12:10] == 3'h0 && reg_rdata[7] == 1'b0)
        else $error("undefined bits read nonzero");
    a_unmapped_read: assert property (reg_rd && reg_addr[15:1] != 15'h202C |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_write_read_back: assert property (reg_wr && !cfg_load && reg_addr[15:1] == 15'h202C
        ##1 !reg_wr && !cfg_load ##1 reg_rd && reg_addr == $past(reg_addr, 2)
        |=> reg_rdata == ($past(reg_wdata, 3) & 16'hE37F))
        else $error("read back differs from write");
    a_cfg_load_fields: assert property (cfg_load && !reg_wr ##1 !reg_wr && !cfg_load
        ##1 reg_rd && reg_addr == `OFS_ON_CONFIG
        |=> reg_rdata == {$past(cfg_on_timeslot, 3), 3'h0, $past(cfg_on_mode, 3), 1'b0,
                          $past(cfg_on_vcode_hi, 3), 2'h0})
        else $error("config load fields wrong");
    a_vout_floor: assert property (conv_vcode <= `VCODE_FLOOR |-> conv_vout == `VOUT_MIN)
        else $error("low codes not at floor voltage");
    a_vout_ceiling: assert property (conv_vcode >= `VCODE_CEIL |-> conv_vout == `VOUT_MAX)
        else $error("high codes not saturated");
    a_vout_step: assert property (conv_vcode > `VCODE_FLOOR && conv_vcode < `VCODE_CEIL |->
        conv_vout == `VOUT_MIN + ({8'h00, conv_vcode} - 15'h0008) * `VOUT_STEP)
        else $error("voltage step wrong");
    a_slot_none_off: assert property (reg_wr && reg_addr == `OFS_ON_CONFIG && reg_wdata[15:13] == `SLOT_NONE
        |-> ##[1:3] !conv_enable)
        else $error("slot none left converter on");

    cover property (seq_slot_strobe && seq_sleep ##2 $rose(conv_in_sleep));
    cover property (cfg_load);
    cover property ($fell(conv_enable));
endmodule // buck_cfg_checker

`default_nettype wire

//--- bench/tb_buck_on_sleep_config_regs.sv
`timescale 1ns/1ns
`default_nettype none

module tb_buck_on_sleep_config_regs;
    logic        mclk, rst, reg_wr, reg_rd, cfg_load, hw_enable1_pin, hw_enable2_pin, hw_control_active;
    logic        hw_control_voltage_choice, seq_powerup, seq_sleep, seq_slot_strobe, conv_enable, conv_in_sleep;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [2:0]  cfg_on_timeslot, seq_timeslot;
    logic [1:0]  cfg_on_mode, conv_mode;
    logic [4:0]  cfg_on_vcode_hi;
    logic [6:0]  conv_vcode;
    logic [14:0] conv_vout;
    int          fails = 0;
    int          tests_run = 0;
    // no 4MHz switching exists in this block, so codes above 48h are legal stimulus
    // address, write data, read back, voltage, mode
    logic [15:0] rows [9][5] = '{'{16'h4058, 16'hFFFF, 16'hE37F, 16'h4650, 16'h0003},
        '{16'h4058, 16'h0000, 16'h0000, 16'h1770, 16'h0000}, '{16'h4058, 16'h0108, 16'h0108, 16'h1770, 16'h0001},
        '{16'h4058, 16'h0209, 16'h0209, 16'h17ED, 16'h0002}, '{16'h4058, 16'h0348, 16'h0348, 16'h36B0, 16'h0003},
        '{16'h4058, 16'h0067, 16'h0067, 16'h45D3, 16'h0000}, '{16'h4058, 16'h0068, 16'h0068, 16'h4650, 16'h0000},
        '{16'h4059, 16'hFFFF, 16'hE37F, 16'h4650, 16'h0000}, '{16'h1234, 16'hFFFF, 16'h0000, 16'h4650, 16'h0000}};
    // sleep slot code, its timeslot, a timeslot that must not act
    logic [2:0]  slp [3][3] = '{'{3'h0, 3'h5, 3'h1}, '{3'h6, 3'h3, 3'h4}, '{3'h7, 3'h1, 3'h2}};
    // timeslot in which sleep codes 001 to 101 disable the converter
    logic [2:0]  dis [5] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1};

    buck_on_sleep_config_regs i_buck_on_sleep_config_regs (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_load(cfg_load),
        .cfg_on_timeslot(cfg_on_timeslot), .cfg_on_mode(cfg_on_mode), .cfg_on_vcode_hi(cfg_on_vcode_hi),
        .hw_enable1_pin(hw_enable1_pin), .hw_enable2_pin(hw_enable2_pin), .hw_control_active(hw_control_active),
        .hw_control_voltage_choice(hw_control_voltage_choice), .seq_powerup(seq_powerup), .seq_sleep(seq_sleep),
        .seq_slot_strobe(seq_slot_strobe), .seq_timeslot(seq_timeslot), .conv_enable(conv_enable),
        .conv_in_sleep(conv_in_sleep), .conv_mode(conv_mode), .conv_vcode(conv_vcode), .conv_vout(conv_vout));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // the idle cycle at the end keeps two back-to-back writes from driving the strobe twice in one step
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [15:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        @(posedge mclk);
    endtask

    task automatic stb(input logic pu, input logic sl, input logic [2:0] ts);
        seq_powerup <= pu;
        seq_sleep <= sl;
        seq_timeslot <= ts;
        seq_slot_strobe <= 1'b1;
        @(posedge mclk);
        seq_slot_strobe <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic wait_en(input logic e);
        for (int i = 0; i < 20 && conv_enable !== e; i++) @(posedge mclk);
        chk(conv_enable, e);
        if (conv_enable !== e) tally_and_finish;
    endtask

    initial begin
        {rst, hw_control_active} <= 2'h3;
        {reg_wr, reg_rd, cfg_load, hw_enable1_pin, hw_enable2_pin, hw_control_voltage_choice} <= 6'h00;
        {seq_powerup, seq_sleep, seq_slot_strobe, seq_timeslot, reg_addr, reg_wdata} <= 38'h0;
        {cfg_on_timeslot, cfg_on_mode, cfg_on_vcode_hi} <= 10'h000;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int r = 0; r < 9; r++) begin
            wr(rows[r][0], rows[r][1]);
            rd(rows[r][0]);
            chk(d, rows[r][2]);
            chk(conv_vout, rows[r][3]);
            chk(conv_mode, rows[r][4]);
        end
        wr(16'h4059, 16'h0009);
        hw_control_voltage_choice <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(conv_vout, 16'h17ED);
        {hw_control_voltage_choice, hw_control_active} <= 2'h0;
        for (int n = 1; n < 6; n++) begin
            wr(16'h4058, 16'h0100);
            wr(16'h4058, {3'(n), 13'h0100});
            wr(16'h4059, {3'(n), 13'h0300});
            stb(1'b1, 1'b0, 3'(n % 5 + 1));
            chk(conv_enable, 16'h0000);
            stb(1'b1, 1'b0, 3'(n));
            chk(conv_enable, 16'h0001);
            stb(1'b0, 1'b1, dis[n % 5]);
            chk(conv_enable, 16'h0001);
            stb(1'b0, 1'b1, dis[n - 1]);
            chk(conv_enable, 16'h0000);
        end
        wr(16'h4058, 16'h6100);
        wr(16'h4059, 16'h4300);
        stb(1'b1, 1'b0, 3'h2);
        chk(conv_enable, 16'h0000);
        stb(1'b1, 1'b0, 3'h3);
        chk(conv_enable, 16'h0001);
        stb(1'b0, 1'b1, 3'h5);
        chk(conv_enable, 16'h0001);
        stb(1'b0, 1'b1, 3'h4);
        chk(conv_enable, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            wr(16'h4059, {slp[k][0], 13'h0209});
            stb(1'b1, 1'b0, 3'h3);
            stb(1'b0, 1'b1, slp[k][2]);
            chk(conv_in_sleep, 16'h0000);
            stb(1'b0, 1'b1, slp[k][1]);
            chk(conv_in_sleep, 16'h0001);
            chk(conv_mode, 16'h0002);
            chk(conv_vcode, 16'h0009);
        end
        wr(16'h4059, 16'h4300);
        for (int p = 0; p < 2; p++) begin
            wr(16'h4058, p ? 16'hE100 : 16'hC100);
            wait_en(1'b0);
            if (p) hw_enable2_pin <= 1'b1;
            else hw_enable1_pin <= 1'b1;
            wait_en(1'b1);
            stb(1'b1, 1'b0, 3'h1);
            chk(conv_in_sleep, 16'h0000);
            stb(1'b0, 1'b1, 3'h4);
            chk(conv_enable, 16'h0001);
            chk(conv_in_sleep, 16'h0001);
        end
        wr(16'h4058, 16'h0100);
        wait_en(1'b0);
        {hw_enable1_pin, hw_enable2_pin} <= 2'h0;
        wr(16'h4058, 16'h0003);
        {cfg_on_timeslot, cfg_on_mode, cfg_on_vcode_hi, cfg_load} <= {3'h3, 2'h2, 5'h1F, 1'b1};
        @(posedge mclk);
        cfg_load <= 1'b0;
        @(posedge mclk);
        rd(16'h4058);
        chk(d, 16'h627C);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(16'h4058);
        chk(d, 16'h0100);
        rd(16'h4059);
        chk(d, 16'h0300);
        chk(conv_vout, 16'h1770);
        chk(conv_enable, 16'h0000);
        tally_and_finish;
    end
endmodule // tb_buck_on_sleep_config_regs

bind buck_on_sleep_config_regs buck_cfg_checker i_buck_cfg_checker (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_load(cfg_load),
    .cfg_on_timeslot(cfg_on_timeslot), .cfg_on_mode(cfg_on_mode), .cfg_on_vcode_hi(cfg_on_vcode_hi),
    .seq_slot_strobe(seq_slot_strobe), .seq_sleep(seq_sleep), .conv_enable(conv_enable),
    .conv_in_sleep(conv_in_sleep), .conv_vcode(conv_vcode), .conv_vout(conv_vout));

`default_nettype wire

//--- hw/buck_cfg_regs.vh
`ifndef BUCK_CFG_REGS_VH
`define BUCK_CFG_REGS_VH

// ------------------------------------------------------------
// register offsets, as printed
// ------------------------------------------------------------
`define ADDR_W              16
`define OFS_ON_CONFIG       16'h4058
`define OFS_SLEEP_CONTROL   16'h4059

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SLOT_HI             15
`define SLOT_LO             13
`define MODE_HI             9
`define MODE_LO             8
`define VHI_HI              6
`define VHI_LO              2
`define VLO_HI              1
`define VLO_LO              0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_ON_SLOT         3'h0
`define RST_ON_MODE         2'h1
`define RST_ON_VHI          5'h00
`define RST_ON_VLO          2'h0
`define RST_SLP_SLOT        3'h0
`define RST_SLP_MODE        2'h3
`define RST_SLP_VCODE       7'h00

// ------------------------------------------------------------
// encodings
// ------------------------------------------------------------
`define MODE_FCCM           2'h0
`define MODE_AUTO           2'h1
`define MODE_LINEAR         2'h2
`define MODE_HYST           2'h3
`define SLOT_NONE           3'h0
`define SLOT_LAST_TS        3'h5
`define SLOT_HW_EN1         3'h6
`define SLOT_HW_EN2         3'h7
`define SLP_TS5_SLEEP       3'h0
`define SLP_TS3_SLEEP       3'h6
`define SLP_TS1_SLEEP       3'h7
`define SLP_REVERSE_BASE    3'h6
`define TS_1                3'h1
`define TS_3                3'h3
`define TS_5                3'h5

// ------------------------------------------------------------
// voltage mapping, in units of 0.1 mV
// ------------------------------------------------------------
`define VCODE_FLOOR         7'h08
`define VCODE_CEIL          7'h68
`define VOUT_MIN            15'h1770
`define VOUT_MAX            15'h4650
`define VOUT_STEP           15'h007D

`endif

//--- hw/buck_on_sleep_config_regs.v
//
// Contract
// - on slot 110 follows hardware enable 1; 111 follows hardware enable 2.
// - on mode 9:8 resets 01: FCCM, auto, linear, hysteretic.
// - on voltage code is 7 bits: upper five at 6:2, lower two at 1:0.
// - config memory load sets only upper five on bits; low two return to reset.
// - sleep slot 000, 110, 111 apply sleep settings in timeslot 5, 3, 1.
// - sleep slot 001-101 disables converter in timeslot 5 down to 1.
// - hardware-enabled converter: codes 001-101 pick sleep entry timeslot instead.
// - sleep mode 9:8 resets 11 and uses the on mode encoding.
// - sleep voltage code at 6:0 resets zero, same mapping as on code.
// - under hardware control, choice bit 0 uses on code, 1 uses sleep code.
//
`timescale 1ns/1ns
`default_nettype none
`include "buck_cfg_regs.vh"

module buck_on_sleep_config_regs (
    input  wire                 mclk,
    input  wire                 rst,
    input  wire [15:0]          reg_addr,
    input  wire [15:0]          reg_wdata,
    input  wire                 reg_wr,
    input  wire                 reg_rd,
    output reg  [15:0]          reg_rdata,
    input  wire                 cfg_load,
    input  wire [2:0]           cfg_on_timeslot,
    input  wire [1:0]           cfg_on_mode,
    input  wire [4:0]           cfg_on_vcode_hi,
    input  wire                 hw_enable1_pin,
    input  wire                 hw_enable2_pin,
    input  wire                 hw_control_active,
    input  wire                 hw_control_voltage_choice,
    input  wire                 seq_powerup,
    input  wire                 seq_sleep,
    input  wire                 seq_slot_strobe,
    input  wire [2:0]           seq_timeslot,
    output reg                  conv_enable,
    output reg                  conv_in_sleep,
    output reg  [1:0]           conv_mode,
    output reg  [6:0]           conv_vcode,
    output reg  [14:0]          conv_vout
);

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    reg  [2:0]  on_timeslot_select_r;
    reg  [1:0]  on_operating_mode_r;
    reg  [6:0]  on_voltage_code_r;
    reg  [2:0]  sleep_timeslot_select_r;
    reg  [1:0]  sleep_operating_mode_r;
    reg  [6:0]  sleep_voltage_code_r;

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    reg         seq_enable_r;
    reg         sleep_active_r;
    reg         seq_enable_nxt;
    reg         sleep_active_nxt;

    // ------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------
    wire        hw_en1_level;
    wire        hw_en2_level;
    wire        hw_assigned;
    reg         hw_en_level;
    reg         enable_nxt;
    reg  [1:0]  mode_nxt;
    reg  [6:0]  vcode_nxt;
    reg  [14:0] vout_nxt;
    reg  [14:0] vstep;
    reg  [2:0]  sleep_ts;
    reg         sleep_is_disable;
    reg  [15:0] rdata_nxt;

    wire        wr_on;
    wire        wr_sleep;

    // ------------------------------------------------------------
    // hardware enable pins
    // ------------------------------------------------------------
    pin_sync u_sync_en1 (
        .mclk    (mclk),
        .rst     (rst),
        .pin_in  (hw_enable1_pin),
        .level_r (hw_en1_level)
    );

    pin_sync u_sync_en2 (
        .mclk    (mclk),
        .rst     (rst),
        .pin_in  (hw_enable2_pin),
        .level_r (hw_en2_level)
    );

    // a pin-driven converter ignores the sequencer's on and off slots
    assign hw_assigned = (on_timeslot_select_r == `SLOT_HW_EN1) ||
                         (on_timeslot_select_r == `SLOT_HW_EN2);

    always @* begin
        if (on_timeslot_select_r == `SLOT_HW_EN2) begin
            hw_en_level = hw_en2_level;
        end else begin
            hw_en_level = hw_en1_level;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    assign wr_on    = reg_wr && (reg_addr == `OFS_ON_CONFIG);
    assign wr_sleep = reg_wr && (reg_addr == `OFS_SLEEP_CONTROL);

    // a software write in the same cycle as a memory load wins,
    // since it is the later, deliberate setting
    always @(posedge mclk) begin
        if (rst) begin
            on_timeslot_select_r <= `RST_ON_SLOT;
            on_operating_mode_r  <= `RST_ON_MODE;
            on_voltage_code_r    <= {`RST_ON_VHI, `RST_ON_VLO};
        end else if (wr_on) begin
            on_timeslot_select_r <= reg_wdata[`SLOT_HI:`SLOT_LO];
            on_operating_mode_r  <= reg_wdata[`MODE_HI:`MODE_LO];
            on_voltage_code_r    <= {reg_wdata[`VHI_HI:`VHI_LO],
                                     reg_wdata[`VLO_HI:`VLO_LO]};
        end else if (cfg_load) begin
            on_timeslot_select_r <= cfg_on_timeslot;
            on_operating_mode_r  <= cfg_on_mode;
            on_voltage_code_r    <= {cfg_on_vcode_hi, `RST_ON_VLO};
        end
    end

    // ------------------------------------------------------------
    // sleep control register
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            sleep_timeslot_select_r <= `RST_SLP_SLOT;
            sleep_operating_mode_r  <= `RST_SLP_MODE;
            sleep_voltage_code_r    <= `RST_SLP_VCODE;
        end else if (wr_sleep) begin
            sleep_timeslot_select_r <= reg_wdata[`SLOT_HI:`SLOT_LO];
            sleep_operating_mode_r  <= reg_wdata[`MODE_HI:`MODE_LO];
            sleep_voltage_code_r    <= reg_wdata[`VHI_HI:`VLO_LO];
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // unused bits zero
    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            `OFS_ON_CONFIG: begin
                rdata_nxt[`SLOT_HI:`SLOT_LO] = on_timeslot_select_r;
                rdata_nxt[`MODE_HI:`MODE_LO] = on_operating_mode_r;
                rdata_nxt[`VHI_HI:`VLO_LO]   = on_voltage_code_r;
            end
            `OFS_SLEEP_CONTROL: begin
                rdata_nxt[`SLOT_HI:`SLOT_LO] = sleep_timeslot_select_r;
                rdata_nxt[`MODE_HI:`MODE_LO] = sleep_operating_mode_r;
                rdata_nxt[`VHI_HI:`VLO_LO]   = sleep_voltage_code_r;
            end
            default: begin
                rdata_nxt = 16'h0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // read data register
    // ------------------------------------------------------------
    // read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // sleep slot decode
    // ------------------------------------------------------------
    always @* begin
        sleep_ts         = `TS_5;
        sleep_is_disable = 1'b0;
        case (sleep_timeslot_select_r)
            `SLP_TS5_SLEEP: begin
                sleep_ts = `TS_5;
            end
            `SLP_TS3_SLEEP: begin
                sleep_ts = `TS_3;
            end
            `SLP_TS1_SLEEP: begin
                sleep_ts = `TS_1;
            end
            default: begin
                sleep_ts = `SLP_REVERSE_BASE - sleep_timeslot_select_r;
                sleep_is_disable = !hw_assigned;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencer response
    // ------------------------------------------------------------
    // actions happen only on the strobe that opens a timeslot, except that on slot 000 clears the enable in any cycle;
    // power-up takes precedence if the sequencer drives both levels
    always @* begin
        seq_enable_nxt   = seq_enable_r;
        sleep_active_nxt = sleep_active_r;
        if (seq_slot_strobe && seq_powerup) begin
            sleep_active_nxt = 1'b0;
            if ((on_timeslot_select_r != `SLOT_NONE) &&
                (on_timeslot_select_r <= `SLOT_LAST_TS) &&
                (seq_timeslot == on_timeslot_select_r)) begin
                seq_enable_nxt = 1'b1;
            end
        end else if (seq_slot_strobe && seq_sleep) begin
            if (seq_timeslot == sleep_ts) begin
                if (sleep_is_disable) begin
                    seq_enable_nxt = 1'b0;
                end else begin
                    sleep_active_nxt = 1'b1;
                end
            end
        end
        if (on_timeslot_select_r == `SLOT_NONE) begin
            seq_enable_nxt = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // sequencer flops
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            seq_enable_r   <= 1'b0;
            sleep_active_r <= 1'b0;
        end else begin
            seq_enable_r   <= seq_enable_nxt;
            sleep_active_r <= sleep_active_nxt;
        end
    end

    // ------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------
    // enable follows pin for on slot 110 or 111, else the sequencer
    always @* begin
        if (hw_assigned) begin
            enable_nxt = hw_en_level;
        end else begin
            enable_nxt = seq_enable_r;
        end
    end

    always @* begin
        if (sleep_active_r) begin
            mode_nxt = sleep_operating_mode_r;
        end else begin
            mode_nxt = on_operating_mode_r;
        end
    end

    // ------------------------------------------------------------
    // voltage code selection
    // ------------------------------------------------------------
    // hardware control overrides the code only; the mode still
    // follows the sequencer's sleep state
    // hardware voltage choice
    always @* begin
        if (hw_control_active) begin
            if (hw_control_voltage_choice) begin
                vcode_nxt = sleep_voltage_code_r;
            end else begin
                vcode_nxt = on_voltage_code_r;
            end
        end else if (sleep_active_r) begin
            vcode_nxt = sleep_voltage_code_r;
        end else begin
            vcode_nxt = on_voltage_code_r;
        end
    end

    // ------------------------------------------------------------
    // voltage mapping
    // ------------------------------------------------------------
    // the 4MHz ceiling is software's to respect; nothing here
    // clamps the code, so a faulty setting shows on conv_vcode
    always @* begin
        vstep = {8'h00, vcode_nxt} - {8'h00, `VCODE_FLOOR};
        if (vcode_nxt <= `VCODE_FLOOR) begin
            vout_nxt = `VOUT_MIN;
        end else if (vcode_nxt >= `VCODE_CEIL) begin
            vout_nxt = `VOUT_MAX;
        end else begin
            vout_nxt = `VOUT_MIN + vstep * `VOUT_STEP;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            conv_enable   <= 1'b0;
            conv_in_sleep <= 1'b0;
            conv_mode     <= `RST_ON_MODE;
            conv_vcode    <= {`RST_ON_VHI, `RST_ON_VLO};
            conv_vout     <= `VOUT_MIN;
        end else begin
            conv_enable   <= enable_nxt;
            conv_in_sleep <= sleep_active_r;
            conv_mode     <= mode_nxt;
            conv_vcode    <= vcode_nxt;
            conv_vout     <= vout_nxt;
        end
    end

endmodule // buck_on_sleep_config_regs

`default_nettype wire

//--- hw/pin_sync.v
`timescale 1ns/1ns
`default_nettype none

// three-stage synchroniser; the output follows only once stages
// two and three agree, so a single-cycle glitch is ignored
module pin_sync (
    input  wire mclk,
    input  wire rst,
    input  wire pin_in,
    output reg  level_r
);

    reg meta_r;
    reg s2_r;
    reg s3_r;

    always @(posedge mclk) begin
        if (rst) begin
            meta_r  <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            s2_r   <= meta_r;
            s3_r   <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

endmodule // pin_sync

`default_nettype wire
